// ---- ifc_map.vh ----
/*
 * ifc_map.vh: register selects, field positions and reset values of the
 * interrupt flag, wake-up and control logic.
 * Assumes it is included by bare name from the interrupt controller file only.
 */
`ifndef IFC_MAP_VH
`define IFC_MAP_VH

// register-file selects seen on the core's register port
`define IFC_SEL_WAKE 4'he
`define IFC_SEL_FLAGS 4'hf
`define IFC_PAGE_WAKE 1'b0

// interrupt flag positions
`define IFC_F_TIMER 0
`define IFC_F_AUX_A 1
`define IFC_F_AUX_B 2
`define IFC_F_EXT_A 3
`define IFC_F_EXT_B 4
`define IFC_F_EXT_C 5
`define IFC_F_TONE 6
`define IFC_F_EXT_D 7

// control register fields
`define IFC_C_PSR_HI 2
`define IFC_C_PSR_LO 0
`define IFC_C_ASSIGN 3
`define IFC_C_CTX 4
`define IFC_C_TSRC 5
`define IFC_C_GIE 6
`define IFC_C_POL 7

// wake enable width, reset values and counter maxima
`define IFC_WAKE_W 4
`define IFC_WAKE_RST 4'h0
`define IFC_FLAGS_RST 8'h00
`define IFC_CTRL_RST 8'h00
`define IFC_TIMER_RST 8'h00
`define IFC_TIMER_MAX 8'hff
`define IFC_WDT_MAX 8'hff

`endif

// ---- ifc_edge_sync.v ----
/*
 * ifc_edge_sync.v: two-flop synchroniser and edge detector per input bit.
 * Assumes inputs are asynchronous pins; outputs are one-cycle pulses on
 * ref_clk, one per rising and falling edge seen after synchronisation.
 */
`timescale 1ns/100ps

module ifc_edge_sync #(
    parameter N = 9
) (
    input wire ref_clk,
    input wire rst,
    input wire [N-1:0] pin_in,
    output wire [N-1:0] rise,
    output wire [N-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            reg prev_q;
            // first flop feeds only the second; edges judged on sync/prev
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                    prev_q <= 1'b1;
                end else begin
                    meta_q <= pin_in[i];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end
            assign rise[i] = sync_q & ~prev_q;
            assign fall[i] = ~sync_q & prev_q;
        end
    endgenerate
endmodule

// ---- ifc_prescaler.v ----
/*
 * ifc_prescaler.v: shared 8-bit prescaler with selectable divide ratio.
 * Assumes tick_in is a one-cycle pulse from the source of whichever user
 * holds the prescaler; the owner chooses which output is used.
 */
`timescale 1ns/100ps

module ifc_prescaler #(
    parameter W = 8
) (
    input wire ref_clk,
    input wire rst,
    input wire clear,
    input wire tick_in,
    input wire [2:0] code,
    output wire tick_timer,
    output wire tick_wdt
);
    reg [W-1:0] cnt_q;
    wire [W-1:0] mask_timer;
    wire [W-1:0] mask_wdt;

    // low code+1 bits all ones gives 2^(code+1), low code bits gives 2^code
    assign mask_wdt = ~({W{1'b1}} << code);
    assign mask_timer = {mask_wdt[W-2:0], 1'b1};
    assign tick_timer = tick_in & ((cnt_q & mask_timer) == mask_timer);
    assign tick_wdt = tick_in & ((cnt_q & mask_wdt) == mask_wdt);

    // free running count; clear wins so a write never leaves a stale phase
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
        end else if (clear) begin
            cnt_q <= {W{1'b0}};
        end else if (tick_in) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ---- ifc_irq_ctrl.v ----
/*
 * ifc_irq_ctrl.v: interrupt flags, wake-up enables, control register,
 * main timer, shared prescaler, watchdog and wake reset request.
 * Assumes the core presents register selects and instruction strobes as
 * one-cycle pulses on ref_clk; aux counter overflows come from same-clock
 * logic; port and tone inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/100ps

`include "ifc_map.vh"

module ifc_irq_ctrl #(
    parameter TW = 8,
    parameter PW = 8
) (
    input wire ref_clk,
    input wire rst,
    // core register port
    input wire reg_wr_en,
    input wire [3:0] reg_sel,
    input wire reg_page,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // dedicated control register access
    input wire control_write_instr,
    input wire [7:0] control_wdata,
    output wire [7:0] control_rdata,
    // instruction strobes
    input wire irq_disable_instr,
    input wire irq_enable_instr,
    input wire irq_return_instr,
    input wire watchdog_clear_instr,
    input wire sleep_instr,
    input wire irq_taken,
    // main timer access and sources
    input wire main_timer_wr,
    input wire [TW-1:0] main_timer_wdata,
    output wire [TW-1:0] main_timer_value,
    input wire instr_cycle_tick,
    input wire slow_clk_tick,
    // watchdog
    input wire wdt_enable,
    input wire wdt_src_tick,
    output wire wdt_timeout,
    // event sources
    input wire aux_a_overflow,
    input wire aux_b_overflow,
    input wire [3:0] port7_pin,
    input wire [3:0] port8_pin,
    input wire tone_detect_pin,
    input wire tone_edge_select,
    input wire [7:0] irq_mask,
    // interrupt request and context
    output wire irq_request,
    input wire [7:0] ctx_acc_in,
    input wire [7:0] ctx_status_in,
    input wire ctx_page_in,
    output wire [7:0] ctx_acc_out,
    output wire [7:0] ctx_status_out,
    output wire ctx_page_out,
    output wire ctx_restore,
    // deep sleep wake reset
    input wire deep_sleep,
    output wire wake_reset
);
    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [`IFC_WAKE_W-1:0] wake_en_q;
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [TW-1:0] timer_q;
    reg [7:0] wdt_cnt_q;
    reg wdt_to_q;
    reg wake_rst_q;
    reg [7:0] acc_save_q;
    reg [7:0] stat_save_q;
    reg page_save_q;
    reg restore_q;

    wire [8:0] rise;
    wire [8:0] fall;
    wire [7:0] set_ev;
    wire assign_wdt;
    wire timer_src;
    wire psc_clear;
    wire psc_in;
    wire psc_tick_t;
    wire psc_tick_w;
    wire timer_tick;
    wire wdt_tick;
    wire timer_ovf;
    wire wdt_ovf;
    wire ext_a_ev;
    wire tone_ev;
    wire [3:0] p8_wake;
    wire p7_wake;
    wire wr_flags;
    wire wr_wake;

    // port-7 0..3, port-8 0..3 and tone line, all asynchronous
    ifc_edge_sync #(
        .N(9)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in({tone_detect_pin, port8_pin, port7_pin}),
        .rise(rise),
        .fall(fall)
    );

    assign assign_wdt = ctrl_q[`IFC_C_ASSIGN];
    // timer source choice; the slow tick is supplied already divided
    assign timer_src = ctrl_q[`IFC_C_TSRC] ? slow_clk_tick : instr_cycle_tick;

    // prescaler input follows its owner, never both at once
    assign psc_in = assign_wdt ? wdt_src_tick : timer_src;
    // sleep clears only when the watchdog owns it
    assign psc_clear = main_timer_wr
        | (assign_wdt & (watchdog_clear_instr | sleep_instr));

    ifc_prescaler #(
        .W(PW)
    ) u_psc (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(psc_clear),
        .tick_in(psc_in),
        .code(ctrl_q[`IFC_C_PSR_HI:`IFC_C_PSR_LO]),
        .tick_timer(psc_tick_t),
        .tick_wdt(psc_tick_w)
    );

    // the user without the prescaler runs straight from its own source
    assign timer_tick = assign_wdt ? timer_src : psc_tick_t;
    assign wdt_tick = assign_wdt ? psc_tick_w : wdt_src_tick;

    // main timer: write presets, ticks count up
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timer_q <= `IFC_TIMER_RST;
        end else if (main_timer_wr) begin
            timer_q <= main_timer_wdata;
        end else if (timer_tick) begin
            timer_q <= timer_q + {{(TW-1){1'b0}}, 1'b1};
        end
    end
    assign timer_ovf = timer_tick & ~main_timer_wr
        & (timer_q == `IFC_TIMER_MAX);
    assign main_timer_value = timer_q;

    // watchdog counter; clear and sleep restart it
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wdt_cnt_q <= 8'h00;
            wdt_to_q <= 1'b0;
        end else begin
            wdt_to_q <= wdt_ovf;
            if (~wdt_enable | watchdog_clear_instr | sleep_instr) begin
                wdt_cnt_q <= 8'h00;
            end else if (wdt_tick) begin
                wdt_cnt_q <= wdt_cnt_q + 8'h01;
            end
        end
    end
    assign wdt_ovf = wdt_enable & wdt_tick & ~watchdog_clear_instr
        & ~sleep_instr & (wdt_cnt_q == `IFC_WDT_MAX);
    assign wdt_timeout = wdt_to_q;

    // edge choices for pin 0 and the tone line
    assign ext_a_ev = ctrl_q[`IFC_C_POL] ? fall[0] : rise[0];
    assign tone_ev = fall[8] | (tone_edge_select & rise[8]);

    // event vector in flag order
    assign set_ev[`IFC_F_TIMER] = timer_ovf;
    assign set_ev[`IFC_F_AUX_A] = aux_a_overflow;
    assign set_ev[`IFC_F_AUX_B] = aux_b_overflow;
    assign set_ev[`IFC_F_EXT_A] = ext_a_ev;
    assign set_ev[`IFC_F_EXT_B] = fall[1];
    assign set_ev[`IFC_F_EXT_C] = fall[2];
    assign set_ev[`IFC_F_TONE] = tone_ev;
    assign set_ev[`IFC_F_EXT_D] = fall[3];

    assign wr_flags = reg_wr_en & (reg_sel == `IFC_SEL_FLAGS);
    assign wr_wake = reg_wr_en & (reg_sel == `IFC_SEL_WAKE)
        & (reg_page == `IFC_PAGE_WAKE);

    // writing a zero clears; a set in the same cycle still wins
    always @* begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = flags_q & reg_wdata;
        end
        flags_d = flags_d | set_ev;
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_q <= `IFC_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // wake-up enables, low four bits only
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_en_q <= `IFC_WAKE_RST;
        end else if (wr_wake) begin
            wake_en_q <= reg_wdata[`IFC_WAKE_W-1:0];
        end
    end

    // register read; unused upper wake bits read as zero
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_sel == `IFC_SEL_FLAGS) begin
            reg_rdata <= flags_q;
        end else if (reg_sel == `IFC_SEL_WAKE && reg_page == `IFC_PAGE_WAKE) begin
            reg_rdata <= {4'h0, wake_en_q};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // control register: the dedicated strobe writes it, the register port cannot; irq strobes set and clear the global enable bit
    always @* begin
        ctrl_d = ctrl_q;
        if (control_write_instr) begin
            ctrl_d = control_wdata;
        end
        if (irq_enable_instr | irq_return_instr) begin
            ctrl_d[`IFC_C_GIE] = 1'b1;
        end
        // disabling takes priority so a taken irq is never re-enabled
        if (irq_disable_instr | irq_taken) begin
            ctrl_d[`IFC_C_GIE] = 1'b0;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `IFC_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    assign control_rdata = ctrl_q;

    // request only while flag, mask and global enable agree
    assign irq_request = ctrl_q[`IFC_C_GIE] & |(flags_q & irq_mask);

    // context backup on entry, restore pulse on return
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_save_q <= 8'h00;
            stat_save_q <= 8'h00;
            page_save_q <= 1'b0;
            restore_q <= 1'b0;
        end else begin
            restore_q <= irq_return_instr & ctrl_q[`IFC_C_CTX];
            if (irq_taken & ctrl_q[`IFC_C_CTX]) begin
                acc_save_q <= ctx_acc_in;
                stat_save_q <= ctx_status_in;
                page_save_q <= ctx_page_in;
            end
        end
    end
    assign ctx_acc_out = acc_save_q;
    assign ctx_status_out = stat_save_q;
    assign ctx_page_out = page_save_q;
    assign ctx_restore = restore_q;

    // wake sources: port-8 falling edges per enable, masked port-7 edges
    assign p8_wake = fall[7:4] & wake_en_q;
    assign p7_wake = |({set_ev[`IFC_F_EXT_D], set_ev[`IFC_F_EXT_C],
        set_ev[`IFC_F_EXT_B], set_ev[`IFC_F_EXT_A]}
        & {irq_mask[`IFC_F_EXT_D], irq_mask[`IFC_F_EXT_C],
        irq_mask[`IFC_F_EXT_B], irq_mask[`IFC_F_EXT_A]});

    // deep sleep: any wake source restarts the device from address zero
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_rst_q <= 1'b0;
        end else begin
            wake_rst_q <= deep_sleep & (wdt_ovf | (|p8_wake) | p7_wake);
        end
    end
    assign wake_reset = wake_rst_q;
endmodule

// ---- ifc_irq_monitor.sv ----
/* ifc_irq_monitor.sv: port assertions for ifc_irq_ctrl.
   assumes a bind by port name and the single ref_clk domain. */
`timescale 1ns/100ps
module ifc_irq_monitor #(
    parameter TW = 8
) (
    input wire ref_clk,
    input wire rst,
    input wire control_write_instr,
    input wire [7:0] control_wdata,
    input wire [7:0] control_rdata,
    input wire irq_disable_instr,
    input wire irq_enable_instr,
    input wire irq_return_instr,
    input wire irq_taken,
    input wire main_timer_wr,
    input wire [TW-1:0] main_timer_wdata,
    input wire [TW-1:0] main_timer_value,
    input wire [7:0] ctx_acc_in,
    input wire [7:0] ctx_acc_out,
    input wire ctx_restore,
    input wire irq_request,
    input wire deep_sleep,
    input wire wake_reset
);
    // one domain, so clock and reset are given once
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // clearing the global enable beats setting it
    wire gie_off = irq_disable_instr | irq_taken;
    wire gie_on = irq_enable_instr | irq_return_instr;
    gie_clear_a:
        assert property (gie_off |=> !control_rdata[6])
            else $error("global enable not cleared");
    gie_set_a:
        assert property (gie_on && !gie_off |=> control_rdata[6])
            else $error("global enable not set");
    ctrl_write_a:
        assert property (control_write_instr && !gie_off && !gie_on
            |=> control_rdata == $past(control_wdata))
            else $error("control write lost");
    irq_gate_a:
        assert property (irq_request |-> control_rdata[6])
            else $error("request while globally disabled");
    ctx_save_a:
        assert property (irq_taken && control_rdata[4]
            |=> ctx_acc_out == $past(ctx_acc_in))
            else $error("context not saved");
    ctx_rest_a:
        assert property (irq_return_instr
            |=> ctx_restore == $past(control_rdata[4]))
            else $error("restore pulse wrong");
    wake_sleep_a:
        assert property (wake_reset |-> $past(deep_sleep))
            else $error("wake reset outside deep sleep");
    timer_load_a:
        assert property (main_timer_wr
            |=> main_timer_value == $past(main_timer_wdata))
            else $error("timer preset lost");
    // main scenarios reached
    cover property (irq_request ##1 irq_taken);
    cover property (ctx_restore);
    cover property (wake_reset);
endmodule

// ---- ifc_far.sv ----
/* ifc_far.sv: far side model: port pins, tone output and tick sources.
   assumes the bench calls its tasks; pins idle high, ticks are pulses. */
`timescale 1ns/100ps
module ifc_far (
    input wire ref_clk,
    output reg [3:0] port7_pin,
    output reg [3:0] port8_pin,
    output reg tone_detect_pin,
    output wire aux_a_overflow,
    output wire aux_b_overflow,
    output wire instr_cycle_tick,
    output wire slow_clk_tick,
    output wire wdt_src_tick
);
    reg [4:0] ev_q = 5'h00;
    // pulse sources leave as one vector
    assign {wdt_src_tick, slow_clk_tick, instr_cycle_tick, aux_b_overflow,
        aux_a_overflow} = ev_q;
    // idle high, so reset release shows no edge
    initial begin
        port7_pin = 4'hf;
        port8_pin = 4'hf;
        tone_detect_pin = 1'b1;
    end
    // levels move off the edge, then wait out the synchroniser
    task pins(input [8:0] v);
        begin
            @(negedge ref_clk);
            {tone_detect_pin, port8_pin, port7_pin} = v;
            repeat (5) @(negedge ref_clk);
        end
    endtask
    // one-cycle pulse, as same-clock counters give
    task pulse(input [4:0] m);
        begin
            @(negedge ref_clk);
            ev_q = m;
            @(negedge ref_clk);
            ev_q = 5'h00;
        end
    endtask
endmodule

// ---- tb.sv ----
/* tb.sv: self-checking bench for ifc_irq_ctrl.
   assumes ifc_far supplies pins and ticks; inputs move at falling edges. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
    comparisons = comparisons + 1; \
    if ((g) !== (e)) begin \
        errors = errors + 1; \
        $display("unexpected %s exp %h seen %h", n, e, g); \
    end \
end
module tb;
    reg ref_clk = 1'b0, rst = 1'b1, reg_page = 1'b0;
    reg tone_edge_select = 1'b0, wdt_enable = 1'b0, deep_sleep = 1'b0;
    reg ctx_page_in = 1'b0;
    reg [8:0] st = 9'h000;
    wire ctx_page_out;
    reg [3:0] reg_sel = 4'hf;
    reg [7:0] wd = 8'h00, irq_mask = 8'h00, ctx_acc_in = 8'h00;
    wire [7:0] reg_rdata, control_rdata, main_timer_value, ctx_acc_out;
    wire ctx_restore, irq_request, wake_reset, wdt_timeout;
    wire [3:0] port7_pin, port8_pin;
    wire tone_detect_pin, aux_a_overflow, aux_b_overflow;
    wire instr_cycle_tick, slow_clk_tick, wdt_src_tick;
    integer errors = 0, comparisons = 0;
    integer cyc = 0, rh = 0, wh = 0, th = 0, i;
    ifc_far i_ifc_far (.ref_clk, .port7_pin, .port8_pin, .tone_detect_pin,
        .aux_a_overflow, .aux_b_overflow, .instr_cycle_tick, .slow_clk_tick,
        .wdt_src_tick);
    ifc_irq_ctrl #(.TW(8), .PW(8)) i_ifc_irq_ctrl (.ref_clk, .rst,
        .reg_wr_en(st[0]), .reg_sel, .reg_page, .reg_wdata(wd), .reg_rdata,
        .control_write_instr(st[1]), .control_wdata(wd), .control_rdata,
        .irq_disable_instr(st[4]), .irq_enable_instr(st[3]),
        .irq_return_instr(st[5]), .watchdog_clear_instr(st[7]),
        .sleep_instr(st[8]), .irq_taken(st[6]), .main_timer_wr(st[2]),
        .main_timer_wdata(wd), .main_timer_value, .instr_cycle_tick,
        .slow_clk_tick, .wdt_enable, .wdt_src_tick, .wdt_timeout,
        .aux_a_overflow, .aux_b_overflow, .port7_pin, .port8_pin,
        .tone_detect_pin, .tone_edge_select, .irq_mask, .irq_request,
        .ctx_acc_in, .ctx_status_in(ctx_acc_in), .ctx_page_in,
        .ctx_acc_out, .ctx_status_out(), .ctx_page_out, .ctx_restore,
        .deep_sleep, .wake_reset);
    always #2 ref_clk = ~ref_clk;
    task final_report;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // pulse counters and hang guard
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        rh = rh + (ctx_restore === 1'b1);
        wh = wh + (wake_reset === 1'b1);
        th = th + (wdt_timeout === 1'b1);
        if (cyc == 20000) begin
            errors = errors + 1;
            final_report;
        end
    end
    // strobes rise one falling edge, drop the next
    task strobe(input [8:0] s);
        begin
            @(negedge ref_clk);
            st = s;
            @(negedge ref_clk);
            st = 9'h000;
        end
    endtask
    task wr(input [3:0] s, input p, input [7:0] d);
        begin
            reg_sel = s;
            reg_page = p;
            wd = d;
            strobe(8'h01);
        end
    endtask
    // read data lags the select by a cycle
    task rf(input [3:0] s, input p, input [7:0] e);
        begin
            @(negedge ref_clk);
            reg_sel = s;
            reg_page = p;
            repeat (2) @(negedge ref_clk);
            `CHK("reg_rdata", e, reg_rdata)
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rf(4'hf, 1'b0, 8'h00);
        `CHK("control", 8'h00, control_rdata)
        wr(4'he, 1'b0, 8'hff);
        rf(4'he, 1'b0, 8'h0f);
        rf(4'he, 1'b1, 8'h00);
        i_ifc_far.pulse(5'h03);
        rf(4'hf, 1'b0, 8'h06);
        wr(4'hf, 1'b0, 8'hfb);
        rf(4'hf, 1'b0, 8'h02);
        $display("test flags done");
        irq_mask = 8'h02;
        wd = 8'h10;
        strobe(8'h02);
        `CHK("irq_request", 1'b0, irq_request)
        strobe(8'h08);
        `CHK("control", 8'h50, control_rdata)
        `CHK("irq_request", 1'b1, irq_request)
        ctx_acc_in = 8'h5a;
        ctx_page_in = 1'b1;
        strobe(8'h40);
        `CHK("ctx_acc_out", 8'h5a, ctx_acc_out)
        `CHK("ctx_page_out", 1'b1, ctx_page_out)
        `CHK("control", 8'h10, control_rdata)
        strobe(8'h20);
        `CHK("control", 8'h50, control_rdata)
        strobe(8'h10);
        `CHK("restores", 1, rh)
        `CHK("irq_request", 1'b0, irq_request)
        irq_mask = 8'h00;
        wr(4'hf, 1'b0, 8'h00);
        $display("test irq done");
        i_ifc_far.pins(9'h1f1);
        rf(4'hf, 1'b0, 8'hb0);
        i_ifc_far.pins(9'h1ff);
        rf(4'hf, 1'b0, 8'hb0);
        wr(4'hf, 1'b0, 8'h00);
        i_ifc_far.pins(9'h1fe);
        rf(4'hf, 1'b0, 8'h00);
        i_ifc_far.pins(9'h1ff);
        rf(4'hf, 1'b0, 8'h08);
        wr(4'hf, 1'b0, 8'h00);
        wd = 8'h80;
        strobe(8'h02);
        i_ifc_far.pins(9'h1fe);
        rf(4'hf, 1'b0, 8'h08);
        i_ifc_far.pins(9'h0ff);
        rf(4'hf, 1'b0, 8'h48);
        wr(4'hf, 1'b0, 8'h00);
        i_ifc_far.pins(9'h1ff);
        rf(4'hf, 1'b0, 8'h00);
        tone_edge_select = 1'b1;
        i_ifc_far.pins(9'h0ff);
        wr(4'hf, 1'b0, 8'h00);
        i_ifc_far.pins(9'h1ff);
        rf(4'hf, 1'b0, 8'h40);
        wr(4'hf, 1'b0, 8'h00);
        $display("test edges done");
        wd = 8'h01;
        strobe(8'h02);
        wd = 8'hff;
        strobe(8'h04);
        `CHK("timer", 8'hff, main_timer_value)
        for (i = 0; i < 3; i = i + 1)
            i_ifc_far.pulse(5'h04);
        i_ifc_far.pulse(5'h08);
        strobe(9'h100);
        rf(4'hf, 1'b0, 8'h00);
        i_ifc_far.pulse(5'h04);
        rf(4'hf, 1'b0, 8'h01);
        `CHK("timer", 8'h00, main_timer_value)
        $display("test timer done");
        wd = 8'h09;
        strobe(8'h02);
        wdt_enable = 1'b1;
        strobe(8'h80);
        for (i = 0; i < 511; i = i + 1)
            i_ifc_far.pulse(5'h10);
        repeat (3) @(negedge ref_clk);
        `CHK("timeouts", 0, th)
        i_ifc_far.pulse(5'h10);
        repeat (3) @(negedge ref_clk);
        `CHK("timeouts", 1, th)
        wdt_enable = 1'b0;
        $display("test watchdog done");
        deep_sleep = 1'b1;
        wr(4'he, 1'b0, 8'h0e);
        i_ifc_far.pins(9'h1ef);
        `CHK("wakes", 0, wh)
        i_ifc_far.pins(9'h1ff);
        wr(4'he, 1'b0, 8'h01);
        i_ifc_far.pins(9'h1ef);
        `CHK("wakes", 1, wh)
        deep_sleep = 1'b0;
        $display("test wake done");
        final_report;
    end
endmodule
bind ifc_irq_ctrl ifc_irq_monitor #(.TW(TW)) i_ifc_irq_monitor (.ref_clk,
    .rst, .control_write_instr, .control_wdata, .control_rdata,
    .irq_disable_instr, .irq_enable_instr, .irq_return_instr, .irq_taken,
    .main_timer_wr, .main_timer_wdata, .main_timer_value, .ctx_acc_in,
    .ctx_acc_out, .ctx_restore, .irq_request, .deep_sleep, .wake_reset);
